// ### inc/plee_consts.svh
// Constants of the postfix logic equation engine: sizes, fields, offsets, reset values, timing.
`ifndef PLEE_CONSTS_SVH
`define PLEE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define PLEE_NUM_ENTRIES   512
`define PLEE_NUM_TIMERS    32
`define PLEE_NUM_VOUT      64
`define PLEE_NUM_LATCH     32
`define PLEE_STACK_DEPTH   32
`define PLEE_MAX_GATE_IN   16

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PLEE_CLK_NS        4
`define PLEE_TICK_NS       1000000
`define PLEE_MS_PER_S      1000
`define PLEE_S_PER_MIN     60

// ----------------------------------------------------------------------------
// Entry fields and timer setting fields
// ----------------------------------------------------------------------------
`define PLEE_OP_MSB        15
`define PLEE_OP_LSB        12
`define PLEE_ARG_MSB       5
`define PLEE_ARG_LSB       0
`define PLEE_TPK_MSB       15
`define PLEE_TPK_LSB       0
`define PLEE_TUNIT_MSB     17
`define PLEE_TUNIT_LSB     16

// ----------------------------------------------------------------------------
// Register byte addresses and bits
// ----------------------------------------------------------------------------
`define PLEE_REG_CTRL      12'h000
`define PLEE_REG_STATUS    12'h004
`define PLEE_REG_PASSES    12'h008
`define PLEE_REG_VOUT_LO   12'h010
`define PLEE_REG_VOUT_HI   12'h014
`define PLEE_REG_POL_LO    12'h018
`define PLEE_REG_POL_HI    12'h01c
`define PLEE_REG_EN_LO     12'h020
`define PLEE_REG_EN_HI     12'h024
`define PLEE_REG_TMR_BASE  12'h080
`define PLEE_REG_LIST_BASE 12'h800
`define PLEE_CTRL_RUN      0
`define PLEE_CTRL_CLR      1
`define PLEE_ST_LOADED     0
`define PLEE_ST_BUSY       1
`define PLEE_ST_ERR_STK    2
`define PLEE_ST_ERR_DUP    3
`define PLEE_ST_CLEARING   4

// ----------------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------------
`define PLEE_RST_POL       64'hffff_ffff_ffff_ffff
`define PLEE_RST_EN        64'hffff_ffff_ffff_ffff
`define PLEE_RESP_OKAY     2'h0
`define PLEE_RESP_SLVERR   2'h2
`define PLEE_RESP_DECERR   2'h3

`endif

// ### inc/plee_pkg.sv
// Types of the postfix logic equation engine.
`default_nettype none
package plee_pkg;
  `include "plee_consts.svh"

  typedef enum logic [3:0] {
    PLEE_S_IDLE  = 4'h1,
    PLEE_S_CLEAR = 4'h2,
    PLEE_S_FETCH = 4'h4,
    PLEE_S_EVAL  = 4'h8
  } plee_state_e;

  typedef enum logic [3:0] {
    OP_END = 4'h0, OP_ON = 4'h1, OP_OFF = 4'h2, OP_CONT = 4'h3,
    OP_VIN = 4'h4, OP_ELEM = 4'h5, OP_VOUT = 4'h6, OP_NOT = 4'h7,
    OP_AND = 4'h8, OP_OR = 4'h9, OP_NOR = 4'ha, OP_NAND = 4'hb,
    OP_XOR = 4'hc, OP_LATCH = 4'hd, OP_TIMER = 4'he, OP_ASSIGN = 4'hf
  } plee_op_e;

  typedef struct packed {
    plee_state_e st;
    logic [8:0]  pc;
    logic [5:0]  sp;
    logic [31:0] stk;
    logic [63:0] vout;
    logic [31:0] latch;
    logic [31:0] tin;
    logic [31:0][15:0] tcnt;
    logic [31:0][17:0] tcfg;
    logic [31:0] tused;
    logic [63:0] aused;
    logic        loaded;
    logic        err_stk;
    logic        err_dup;
    logic [63:0] pol;
    logic [63:0] elem_en;
    logic [17:0] ms_cnt;
    logic [9:0]  sec_cnt;
    logic [5:0]  min_cnt;
    logic        tick_ms;
    logic        tick_s;
    logic        tick_m;
    logic [31:0] passes;
    logic [63:0] s1;
    logic [63:0] s2;
    logic [63:0] s3;
    logic [63:0] cont_f;
    logic        aw_v;
    logic [11:0] aw_a;
    logic        w_v;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        b_v;
    logic [1:0]  b_r;
    logic        r_v;
    logic [31:0] r_d;
    logic [1:0]  r_r;
    logic        mwe;
    logic [8:0]  mwa;
    logic [15:0] mwd;
  } plee_regs_s;
endpackage
`default_nettype wire

// ### hdl/plee_mem.sv
// Equation entry store with one write port and a registered read port.
`timescale 1ns/1ps
`default_nettype none
module plee_mem #(
  parameter int DEPTH = 512,
  parameter int WIDTH = 16,
  parameter int AW    = 9
) (
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Write port.
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  // Read port.
  input  wire logic [AW-1:0]    i_raddr,
  output logic      [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // The array has no reset; the owner sweeps it after reset instead.
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Read data come from a flop one cycle after the address.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule
`default_nettype wire

// ### hdl/plee_top.sv
// Postfix logic equation engine with an AXI4-Lite register slave.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "plee_consts.svh"
//
// Contract
// - Entries run in stored order; the first end marker stops the pass.
// - Store holds 512 entries, all end markers after reset or clear.
// - A disabled element operand always reads as zero.
// - Thirty-two independent timers, each an operator with its own output.
// - Timer output follows pickup delay; pickup zero passes input straight through.
// - Each timer has a unit select choosing its time base.
// - Inverter complements the single most recent value.
// - An n-input gate consumes the n latest values and yields one.
// - Latch takes reset as latest value and set as the one before.
// - Sixty-four virtual outputs, each assigned by a single entry.
// - A full pass starts at least four times per power cycle.
// - A virtual output read before its assignment yields the last value.
// - A value assigned earlier in a pass is seen by later reads.
// - Constant true and false operands are available anywhere.
// - Each contact operand selects open or closed as its asserted state; the code uses one pol bit per contact, shared by all operands of that contact.
// - Timer starts from the previous value; its output feeds following entries.
// - Assignment ends the equation and leaves no pending values.
// - Latch is reset dominant.
// - Reusing a timer or assignment flags a syntax error and rejects the list.
module plee_top #(
  parameter int unsigned TICK_CYCLES = `PLEE_TICK_NS / `PLEE_CLK_NS
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Operand sources.
  input  wire logic [63:0] i_contact_closed,
  input  wire logic [63:0] i_virtual_input_state,
  input  wire logic [63:0] i_discrete_element_state,
  // Results.
  output logic      [63:0] o_virtual_output_flag,
  // AXI4-Lite write channels.
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [11:0] i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic      [1:0]  o_bresp,
  // AXI4-Lite read channels.
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [11:0] i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic      [31:0] o_rdata,
  output logic      [1:0]  o_rresp
);
  import plee_pkg::*;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------

  // Known register or list word; the decode serves both read and write.
  function automatic logic is_map(input logic [11:0] a);
    is_map = a[11] || (a < 12'h028) || (a[11:7] == 5'h01);
  endfunction

  // Byte-lane merge of a write into an old word.
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      wmerge[8*b +: 8] = s[b] ? d[8*b +: 8] : o[8*b +: 8];
    end
  endfunction

  // Mask of the k lowest stack bits.
  function automatic logic [31:0] gmask(input logic [5:0] k);
    gmask = ~(32'hffff_ffff << k);
  endfunction

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  localparam plee_regs_s RST = '{st: PLEE_S_CLEAR, pol: `PLEE_RST_POL,
                                 elem_en: `PLEE_RST_EN, default: '0};

  plee_regs_s q;
  plee_regs_s n;
  logic [15:0] ent;

  plee_mem #(.DEPTH(`PLEE_NUM_ENTRIES), .WIDTH(16), .AW(9)) u_mem (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_we    (q.mwe),
    .i_waddr (q.mwa),
    .i_wdata (q.mwd),
    .i_raddr (q.pc),
    .o_rdata (ent)
  );

  // Next-state logic for the whole block.
  always_comb begin
    logic [3:0]  op;
    logic [5:0]  arg;
    logic [5:0]  k;
    logic        v;
    logic        push;
    logic        bad;
    logic        dup;
    logic        fin;
    logic        r;
    logic        tk;
    logic        clr;
    logic [31:0] vals;
    logic [31:0] msk;
    logic [31:0] old;
    logic [11:0] a;
    op   = ent[`PLEE_OP_MSB:`PLEE_OP_LSB];
    arg  = ent[`PLEE_ARG_MSB:`PLEE_ARG_LSB];
    k    = '0;
    v    = 1'b0;
    push = 1'b0;
    bad  = 1'b0;
    dup  = 1'b0;
    fin  = 1'b0;
    r    = 1'b0;
    tk   = 1'b0;
    clr  = 1'b0;
    vals = '0;
    msk  = '0;
    old  = '0;
    a    = q.aw_a;
    n = q;
    n.mwe = 1'b0;
    n.tick_ms = 1'b0;
    n.tick_s = 1'b0;
    n.tick_m = 1'b0;

    // Pins pass three flops; a bit moves only when the last two agree.
    n.s1 = i_contact_closed;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.cont_f = (~(q.s2 ^ q.s3) & q.s2) | ((q.s2 ^ q.s3) & q.cont_f);

    // Millisecond divider also paces passes: 16 or more per power cycle.
    if (q.ms_cnt == 18'(TICK_CYCLES - 1)) begin
      n.ms_cnt = '0;
      n.tick_ms = 1'b1;
    end else begin
      n.ms_cnt = q.ms_cnt + 18'h1;
    end
    if (q.tick_ms) begin
      if (q.sec_cnt == 10'(`PLEE_MS_PER_S - 1)) begin
        n.sec_cnt = '0;
        n.tick_s = 1'b1;
      end else begin
        n.sec_cnt = q.sec_cnt + 10'h1;
      end
    end
    if (q.tick_s) begin
      if (q.min_cnt == 6'(`PLEE_S_PER_MIN - 1)) begin
        n.min_cnt = '0;
        n.tick_m = 1'b1;
      end else begin
        n.min_cnt = q.min_cnt + 6'h1;
      end
    end

    // Timer counters: unit 0 counts ms, 1 counts s, 2 and 3 count min.
    for (int i = 0; i < `PLEE_NUM_TIMERS; i++) begin
      case (q.tcfg[i][`PLEE_TUNIT_MSB:`PLEE_TUNIT_LSB])
        2'h0: tk = q.tick_ms;
        2'h1: tk = q.tick_s;
        default: tk = q.tick_m;
      endcase
      if (!q.tin[i]) begin
        n.tcnt[i] = '0;
      end else if (tk && (q.tcnt[i] < q.tcfg[i][`PLEE_TPK_MSB:`PLEE_TPK_LSB])) begin
        n.tcnt[i] = q.tcnt[i] + 16'h1;
      end
    end

    // ----------------------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------------------
    if (i_awvalid && !q.aw_v) begin
      n.aw_v = 1'b1;
      n.aw_a = i_awaddr;
    end
    if (i_wvalid && !q.w_v) begin
      n.w_v = 1'b1;
      n.w_d = i_wdata;
      n.w_s = i_wstrb;
    end
    if (q.b_v && i_bready) begin
      n.b_v = 1'b0;
    end
    // Write runs once address and data are both held and the old answer is gone.
    if (q.aw_v && q.w_v && !q.b_v) begin
      n.aw_v = 1'b0;
      n.w_v = 1'b0;
      n.b_v = 1'b1;
      n.b_r = is_map(a) ? `PLEE_RESP_OKAY : `PLEE_RESP_DECERR;
      if (a[11]) begin
        // The sweep owns the store, so list writes during it are refused.
        if (q.st == PLEE_S_CLEAR) begin
          n.b_r = `PLEE_RESP_SLVERR;
        end else if (q.w_s[1:0] == 2'h3) begin
          n.mwe = 1'b1;
          n.mwa = a[10:2];
          n.mwd = q.w_d[15:0];
          n.loaded = 1'b0;
        end
      end else if (a[11:7] == 5'h01) begin
        old = 32'(q.tcfg[a[6:2]]);
        n.tcfg[a[6:2]] = 18'(wmerge(old, q.w_d, q.w_s));
      end else begin
        case (a)
          `PLEE_REG_CTRL: begin
            if (q.w_s[0]) begin
              // Committing a list restarts all runtime state from false.
              n.loaded = q.w_d[`PLEE_CTRL_RUN] && (q.st != PLEE_S_CLEAR);
              if (q.w_d[`PLEE_CTRL_RUN]) begin
                n.latch = '0;
                n.vout = '0;
                n.tin = '0;
                n.tcnt = '0;
              end
              if (q.w_d[`PLEE_CTRL_CLR]) begin
                n.loaded = 1'b0;
                clr = 1'b1;
              end
            end
          end
          `PLEE_REG_STATUS: begin
            if (q.w_s[0]) begin
              n.err_stk = q.err_stk & ~q.w_d[`PLEE_ST_ERR_STK];
              n.err_dup = q.err_dup & ~q.w_d[`PLEE_ST_ERR_DUP];
            end
          end
          `PLEE_REG_POL_LO: n.pol[31:0] = wmerge(q.pol[31:0], q.w_d, q.w_s);
          `PLEE_REG_POL_HI: n.pol[63:32] = wmerge(q.pol[63:32], q.w_d, q.w_s);
          `PLEE_REG_EN_LO: n.elem_en[31:0] = wmerge(q.elem_en[31:0], q.w_d, q.w_s);
          `PLEE_REG_EN_HI: n.elem_en[63:32] = wmerge(q.elem_en[63:32], q.w_d, q.w_s);
          default: ;
        endcase
      end
    end
    // Read answer is built from the state before this edge.
    if (q.r_v && i_rready) begin
      n.r_v = 1'b0;
    end
    if (i_arvalid && !q.r_v) begin
      n.r_v = 1'b1;
      n.r_r = is_map(i_araddr) ? `PLEE_RESP_OKAY : `PLEE_RESP_DECERR;
      n.r_d = '0;
      if (i_araddr[11:7] == 5'h01) begin
        n.r_d = 32'(q.tcfg[i_araddr[6:2]]);
      end else if (!i_araddr[11]) begin
        case (i_araddr)
          `PLEE_REG_CTRL: n.r_d[`PLEE_CTRL_RUN] = q.loaded;
          `PLEE_REG_STATUS: begin
            n.r_d[`PLEE_ST_LOADED] = q.loaded;
            n.r_d[`PLEE_ST_BUSY] = (q.st == PLEE_S_FETCH) || (q.st == PLEE_S_EVAL);
            n.r_d[`PLEE_ST_ERR_STK] = q.err_stk;
            n.r_d[`PLEE_ST_ERR_DUP] = q.err_dup;
            n.r_d[`PLEE_ST_CLEARING] = (q.st == PLEE_S_CLEAR);
          end
          `PLEE_REG_PASSES: n.r_d = q.passes;
          `PLEE_REG_VOUT_LO: n.r_d = q.vout[31:0];
          `PLEE_REG_VOUT_HI: n.r_d = q.vout[63:32];
          `PLEE_REG_POL_LO: n.r_d = q.pol[31:0];
          `PLEE_REG_POL_HI: n.r_d = q.pol[63:32];
          `PLEE_REG_EN_LO: n.r_d = q.elem_en[31:0];
          `PLEE_REG_EN_HI: n.r_d = q.elem_en[63:32];
          default: ;
        endcase
      end
    end

    // ----------------------------------------------------------------------------
    // Evaluator
    // ----------------------------------------------------------------------------
    case (q.st)
      PLEE_S_IDLE: begin
        if (q.loaded && q.tick_ms && !q.err_stk && !q.err_dup) begin
          n.st = PLEE_S_FETCH;
          n.pc = '0;
          n.sp = '0;
          n.stk = '0;
          n.tused = '0;
          n.aused = '0;
        end
      end
      PLEE_S_CLEAR: begin
        n.mwe = 1'b1;
        n.mwa = q.pc;
        n.mwd = {OP_END, 12'h000};
        n.pc = q.pc + 9'h1;
        if (q.pc == 9'(`PLEE_NUM_ENTRIES - 1)) begin
          n.st = PLEE_S_IDLE;
          n.pc = '0;
        end
      end
      PLEE_S_FETCH: begin
        // An edit of the list abandons the pass in flight.
        n.st = q.loaded ? PLEE_S_EVAL : PLEE_S_IDLE;
      end
      PLEE_S_EVAL: begin
        k = (op == OP_NOT || op == OP_TIMER || op == OP_ASSIGN) ? 6'h1 :
            (op == OP_LATCH) ? 6'h2 : arg;
        msk = gmask(k);
        vals = q.stk & msk;
        case (op)
          OP_END: fin = 1'b1;
          OP_ON: begin
            v = 1'b1;
            push = 1'b1;
          end
          OP_OFF: push = 1'b1;
          OP_CONT: begin
            v = ~(q.cont_f[arg] ^ q.pol[arg]);
            push = 1'b1;
          end
          OP_VIN: begin
            v = i_virtual_input_state[arg];
            push = 1'b1;
          end
          OP_ELEM: begin
            v = q.elem_en[arg] & i_discrete_element_state[arg];
            push = 1'b1;
          end
          OP_VOUT: begin
            v = q.vout[arg];
            push = 1'b1;
          end
          OP_NOT: r = ~q.stk[0];
          OP_AND: r = (vals == msk);
          OP_OR: r = |vals;
          OP_NOR: r = ~|vals;
          OP_NAND: r = ~(vals == msk);
          OP_XOR: r = ^vals;
          OP_LATCH: begin
            r = ~q.stk[0] & (q.stk[1] | q.latch[arg[4:0]]);
            n.latch[arg[4:0]] = r;
          end
          OP_TIMER: begin
            dup = q.tused[arg[4:0]];
            n.tused[arg[4:0]] = 1'b1;
            n.tin[arg[4:0]] = q.stk[0];
            r = q.stk[0] && ((q.tcfg[arg[4:0]][`PLEE_TPK_MSB:`PLEE_TPK_LSB] == 16'h0) ||
                (q.tcnt[arg[4:0]] >= q.tcfg[arg[4:0]][`PLEE_TPK_MSB:`PLEE_TPK_LSB]));
          end
          OP_ASSIGN: begin
            dup = q.aused[arg];
            n.aused[arg] = 1'b1;
          end
          default: bad = 1'b1;
        endcase
        if (push) begin
          bad = (q.sp == 6'(`PLEE_STACK_DEPTH));
          n.stk = {q.stk[30:0], v};
          n.sp = q.sp + 6'h1;
        end else if (!fin) begin
          // Gate widths outside 2..16 and short stacks are malformed lists.
          if (op >= OP_AND && op <= OP_XOR) begin
            bad = (k < 6'h2) || (k > 6'(`PLEE_MAX_GATE_IN));
          end
          bad = bad || (q.sp < k);
          n.stk = ((q.stk >> k) << 1) | 32'(r);
          n.sp = q.sp - k + 6'h1;
          if (op == OP_ASSIGN && !dup) begin
            n.vout[arg] = q.stk[0];
            n.stk = '0;
            n.sp = '0;
          end
        end
        if (bad || dup) begin
          // A rejected list stays stopped until software clears the error flag and commits again.
          n.err_stk = n.err_stk | bad;
          n.err_dup = n.err_dup | dup;
          n.loaded = 1'b0;
          n.st = PLEE_S_IDLE;
        end else if (fin || q.pc == 9'(`PLEE_NUM_ENTRIES - 1)) begin
          n.st = PLEE_S_IDLE;
          n.passes = q.passes + 32'h1;
        end else begin
          n.pc = q.pc + 9'h1;
          n.st = PLEE_S_FETCH;
        end
      end
      default: n.st = PLEE_S_IDLE;
    endcase
    // A sweep request must win, or the evaluator would drop it mid-pass.
    if (clr) begin
      n.st = PLEE_S_CLEAR;
      n.pc = '0;
    end
  end

  // Single register for all state; reset also starts the store sweep.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign o_virtual_output_flag = q.vout;
  assign o_awready = !q.aw_v;
  assign o_wready  = !q.w_v;
  assign o_bvalid  = q.b_v;
  assign o_bresp   = q.b_r;
  assign o_arready = !q.r_v;
  assign o_rvalid  = q.r_v;
  assign o_rdata   = q.r_d;
  assign o_rresp   = q.r_r;
endmodule
`default_nettype wire

// ### bench/plee_top_sva.sv
// Port checker of the logic equation engine, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
`include "plee_consts.svh"
module plee_top_sva (
  // Clock and reset.
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  // Results.
  input wire logic [63:0] o_virtual_output_flag,
  // Register bus.
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [11:0] i_araddr,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp
);
  // One clock domain, so clocking and reset are declared once for all checks.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_aw; i_awvalid && o_awready; endsequence
  sequence s_w; i_wvalid && o_wready; endsequence
  sequence s_wr; i_awvalid && o_awready && i_wvalid && o_wready && !o_bvalid; endsequence
  sequence s_rd; i_arvalid && o_arready; endsequence
  AST_VOUT_RST: assert property ($rose(i_rst_n) |-> (o_virtual_output_flag == 64'h0) [*8])
    else $error("outputs not clear after reset");
  AST_WR_RESP: assert property (s_wr |-> ##[1:2] o_bvalid)
    else $error("write response missing");
  AST_AW_HELD: assert property (s_aw |=> !o_awready)
    else $error("address ready while address held");
  AST_W_HELD: assert property (s_w |=> !o_wready)
    else $error("data ready while data held");
  AST_B_DONE: assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready && o_wready)
    else $error("write channels not freed after response");
  AST_RD_RESP: assert property (s_rd |=> o_rvalid)
    else $error("read answer late");
  AST_AR_BLOCK: assert property (o_rvalid |-> !o_arready)
    else $error("read address ready while answer pending");
  AST_R_DONE: assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("read answer not withdrawn");
  AST_RD_DEC: assert property (s_rd ##0 (i_araddr == 12'h040) |=>
    o_rresp == `PLEE_RESP_DECERR && o_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule
bind plee_top plee_top_sva u_sva (.*);
`default_nettype wire

// ### bench/tb_plee_top.sv
// Self-checking bench for the logic equation engine.
`timescale 1ns/1ps
`default_nettype none
`include "plee_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_plee_top;
  import plee_pkg::*;
  localparam int TK = 50;
  logic        i_clk = 1'b0, i_rst_n = 1'b0;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic        i_arvalid = 1'b0, i_rready = 1'b0;
  logic [11:0] i_awaddr = 12'h0, i_araddr = 12'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [3:0]  i_wstrb = 4'hf;
  logic [1:0]  o_bresp, o_rresp, last_bresp;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [63:0] i_contact_closed = 64'h0, i_virtual_input_state = 64'h0;
  logic [63:0] i_discrete_element_state = 64'h0, o_virtual_output_flag;
  int          bad_count = 0, num_checks = 0;

  // A short tick keeps the millisecond base from dominating the run time.
  plee_top #(.TICK_CYCLES(TK)) u_dut (.*);

  // Free-running 250 MHz clock.
  initial forever #2 i_clk = ~i_clk;

  // Waits whole ticks and ends mid-cycle, where outputs are settled.
  task automatic tk(input int n);
    repeat (n * TK) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  // Operand inputs change together on a rising edge.
  task automatic setin(input logic [63:0] c, input logic [63:0] v, input logic [63:0] e);
    @(posedge i_clk);
    i_contact_closed <= c;
    i_virtual_input_state <= v;
    i_discrete_element_state <= e;
  endtask

  task automatic rst();
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask

  // Ready is looked at mid-cycle, so the handshake edge is known before it comes.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge i_clk);
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    i_bready <= 1'b1;
    do begin
      @(negedge i_clk);
      ha = i_awvalid && o_awready;
      hw = i_wvalid && o_wready;
      hb = o_bvalid;
      last_bresp = o_bresp;
      @(posedge i_clk);
      if (ha) i_awvalid <= 1'b0;
      if (hw) i_wvalid <= 1'b0;
    end while (!hb);
    i_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    @(posedge i_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do begin
      @(negedge i_clk);
      ha = i_arvalid && o_arready;
      hr = o_rvalid;
      d = o_rdata;
      r = o_rresp;
      @(posedge i_clk);
      if (ha) i_arvalid <= 1'b0;
    end while (!hr);
    i_rready <= 1'b0;
  endtask

  task automatic crd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(d & m, x)
  endtask

  function automatic logic [31:0] ent(input plee_op_e o, input logic [5:0] a);
    return {16'h0, o, 6'h0, a};
  endfunction

  // Every program carries its own end marker, as older entries stay behind.
  task automatic ld(input logic [31:0] p[$]);
    foreach (p[i]) wr(`PLEE_REG_LIST_BASE + 12'(4 * i), p[i]);
    wr(`PLEE_REG_CTRL, 32'h1);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    crd(`PLEE_REG_STATUS, 32'h11, 32'h10);
    `CHK(o_virtual_output_flag, 64'h0)
    wr(`PLEE_REG_LIST_BASE, 32'h0);
    `CHK(last_bresp, `PLEE_RESP_SLVERR)
    do rd(`PLEE_REG_STATUS, d, r); while (d[`PLEE_ST_CLEARING] !== 1'b0);
    crd(`PLEE_REG_POL_LO, 32'hffffffff, 32'hffffffff);
    rd(12'h040, d, r);
    `CHK({r, d}, {`PLEE_RESP_DECERR, 32'h0})
  endtask

  task automatic t_gate();
    ld('{ent(OP_ELEM, 1), ent(OP_CONT, 0), ent(OP_NOT, 0), ent(OP_AND, 2),
         ent(OP_ASSIGN, 2), ent(OP_END, 0), ent(OP_ON, 0), ent(OP_ASSIGN, 9)});
    setin(64'h0, 64'h0, 64'h2);
    tk(2);
    `CHK(o_virtual_output_flag[9:2], 8'h01)
    setin(64'h1, 64'h0, 64'h2);
    tk(2);
    `CHK(o_virtual_output_flag[2], 1'b0)
    wr(`PLEE_REG_POL_LO, 32'hfffffffe);
    tk(2);
    `CHK(o_virtual_output_flag[2], 1'b1)
    wr(`PLEE_REG_EN_LO, 32'hfffffffd);
    tk(2);
    `CHK(o_virtual_output_flag[2], 1'b0)
  endtask

  // Set, hold, both, reset only, none: the latch must remember and let reset win.
  task automatic t_latch();
    logic [9:0] sv;
    logic [4:0] ex;
    sv = {2'd0, 2'd2, 2'd3, 2'd0, 2'd1};
    ex = 5'b00011;
    ld('{ent(OP_VIN, 0), ent(OP_VIN, 1), ent(OP_LATCH, 0), ent(OP_ASSIGN, 0),
         ent(OP_VOUT, 0), ent(OP_ASSIGN, 5), ent(OP_END, 0)});
    for (int i = 0; i < 5; i++) begin
      setin(64'h1, {62'h0, sv[2*i+:2]}, 64'h0);
      tk(2);
      `CHK({o_virtual_output_flag[5], o_virtual_output_flag[0]}, {2{ex[i]}})
    end
  endtask

  task automatic t_timer();
    wr(`PLEE_REG_TMR_BASE, 32'h3);
    `CHK(last_bresp, `PLEE_RESP_OKAY)
    wr(`PLEE_REG_TMR_BASE + 12'h4, 32'h0);
    wr(`PLEE_REG_TMR_BASE + 12'h8, 32'h0001_0001);
    ld('{ent(OP_VIN, 2), ent(OP_TIMER, 0), ent(OP_ASSIGN, 1), ent(OP_VIN, 2),
         ent(OP_TIMER, 1), ent(OP_ASSIGN, 3), ent(OP_VIN, 2), ent(OP_TIMER, 2),
         ent(OP_ASSIGN, 4), ent(OP_END, 0)});
    setin(64'h1, 64'h4, 64'h0);
    tk(2);
    `CHK(o_virtual_output_flag[4:1], 4'b0100)
    tk(5);
    `CHK(o_virtual_output_flag[4:1], 4'b0101)
    setin(64'h1, 64'h0, 64'h0);
    tk(2);
    `CHK(o_virtual_output_flag[4:1], 4'b0000)
  endtask

  task automatic t_err();
    ld('{ent(OP_ON, 0), ent(OP_ASSIGN, 6), ent(OP_ON, 0), ent(OP_ASSIGN, 6), ent(OP_END, 0)});
    tk(2);
    crd(`PLEE_REG_STATUS, 32'h0d, 32'h08);
    wr(`PLEE_REG_STATUS, 32'h8);
    ld('{ent(OP_ON, 0), ent(OP_AND, 2), ent(OP_END, 0)});
    tk(2);
    crd(`PLEE_REG_STATUS, 32'h0d, 32'h04);
    wr(`PLEE_REG_STATUS, 32'h4);
    ld('{ent(OP_VOUT, 7), ent(OP_ASSIGN, 8), ent(OP_OFF, 0), ent(OP_NOT, 0),
         ent(OP_ASSIGN, 6), ent(OP_ON, 0), ent(OP_ASSIGN, 7), ent(OP_END, 0)});
    tk(3);
    `CHK(o_virtual_output_flag[6], 1'b1)
    `CHK(o_virtual_output_flag[8:7], 2'b11)
    rst();
    @(negedge i_clk);
    `CHK(o_virtual_output_flag, 64'h0)
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence.
  initial begin
    rst();
    t_reset();
    t_gate();
    t_latch();
    t_timer();
    t_err();
    report_and_stop();
  end

  // Watchdog: the whole run needs a few thousand cycles, so this margin is ample.
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
